// [rtl/sdp_defs.svh]
`ifndef SDP_DEFS_SVH
`define SDP_DEFS_SVH

// ----------------------------------------------------------------
// Instruction register.
// ----------------------------------------------------------------
`define SDP_IR_W 4
`define SDP_IR_RESET 4'hF
`define SDP_INS_BYPASS 4'hF
`define SDP_INS_CTRL 4'h9
`define SDP_INS_TRACE 4'h8
`define SDP_IR_CAPTURE 4'h1

// ----------------------------------------------------------------
// Debug control register.
// ----------------------------------------------------------------
`define SDP_CTRL_W 32
`define SDP_CTRL_RESET 32'h0000_0000
`define SDP_CTRL_BRK_BIT 12

// ----------------------------------------------------------------
// Trace status codes.
// ----------------------------------------------------------------
`define SDP_CODE_STALL 3'h7
`define SDP_CODE_JUMP_PC 3'h6
`define SDP_CODE_JUMP_NO_PC 3'h5
`define SDP_CODE_EXCEPTION 3'h4
`define SDP_CODE_SEQUENTIAL 3'h3
`define SDP_CODE_TRACE_STALL 3'h2
`define SDP_CODE_TRIGGER 3'h1
`define SDP_CODE_DEBUG 3'h0

// ----------------------------------------------------------------
// Trace path sizes and timing.
// ----------------------------------------------------------------
`define SDP_PC_W 32
`define SDP_PC_CNT_W 6
`define SDP_PC_BITS 6'h20
`define SDP_FIFO_DEPTH 8
`define SDP_FIFO_AW 3
`define SDP_FIFO_W 35
`define SDP_DIV_W 4
`define SDP_TRACE_DIV 4'h2

`endif

// [rtl/sdp_pkg.sv]
package sdp_pkg;

	typedef enum logic [3:0] {
		tap_reset,
		tap_idle,
		tap_sel_dr,
		tap_cap_dr,
		tap_sh_dr,
		tap_ex1_dr,
		tap_pa_dr,
		tap_ex2_dr,
		tap_up_dr,
		tap_sel_ir,
		tap_cap_ir,
		tap_sh_ir,
		tap_ex1_ir,
		tap_pa_ir,
		tap_ex2_ir,
		tap_up_ir
	} sdp_tap_t;

	typedef struct packed {
		sdp_tap_t tap;
		logic tck_p;
		logic [3:0] ir;
		logic [3:0] ir_sh;
		logic [31:0] dr_sh;
		logic [31:0] ctrl;
		logic dms;
		logic tdo;
		logic tdo_oe;
		logic real_mode;
		logic [3:0] div_cnt;
		logic dclk;
		logic [2:0] pcst;
		logic pcst_oe;
		logic [31:0] pc_sh;
		logic [5:0] pc_cnt;
		logic exc;
	} sdp_state_t;

endpackage

// [rtl/sdp_fifo_if.sv]
`timescale 1ns/1ns
`default_nettype none

interface sdp_fifo_if #(
	parameter int W = 35
);
	logic [W-1:0] wdata;
	logic wvalid;
	logic wready;
	logic [W-1:0] rdata;
	logic rvalid;
	logic rready;

	modport store (
		input wdata, wvalid, rready,
		output wready, rdata, rvalid
	);
	modport user (
		output wdata, wvalid, rready,
		input wready, rdata, rvalid
	);
endinterface

`default_nettype wire

// [rtl/sdp_sync.sv]
`timescale 1ns/1ns
`default_nettype none

module sdp_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// Data.
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sdp_sync_t;

	sdp_sync_t s_q;
	sdp_sync_t s_d;

	always_comb begin
		s_d.s1 = d_i;
		s_d.s2 = s_q.s1;
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q_o = s_q.s2;
endmodule

`default_nettype wire

// [rtl/sdp_fifo.sv]
`timescale 1ns/1ns
`default_nettype none

module sdp_fifo #(
	parameter int W = 35,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// Both sides.
	sdp_fifo_if.store f
);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic not_full;
	} sdp_fifo_t;

	sdp_fifo_t s_q;
	sdp_fifo_t s_d;
	logic push;
	logic pop;

	always_comb begin
		s_d = s_q;
		push = f.wvalid && s_q.not_full;
		pop = f.rready && (s_q.cnt != '0);
		if (push) begin
			s_d.mem[s_q.wp] = f.wdata;
			s_d.wp = s_q.wp + 1'b1;
		end
		if (pop) begin
			s_d.rp = s_q.rp + 1'b1;
		end
		if (push && !pop) begin
			s_d.cnt = s_q.cnt + 1'b1;
		end else if (pop && !push) begin
			s_d.cnt = s_q.cnt - 1'b1;
		end
		s_d.not_full = (s_d.cnt != (AW+1)'(DEPTH));
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_q <= '0;
			s_q.not_full <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign f.wready = s_q.not_full;
	assign f.rvalid = (s_q.cnt != '0);
	assign f.rdata = s_q.mem[s_q.rp];
endmodule

`default_nettype wire

// [rtl/sdp_debug_port.sv]
`timescale 1ns/1ns
`default_nettype none
`include "sdp_defs.svh"

module sdp_debug_port (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// Probe pins.
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic dms_i,
	input wire logic tdi_i,
	input wire logic trst_n_i,
	input wire logic debugboot_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	output logic dclk_o,
	output logic [2:0] pcst_o,
	output logic pcst_oe_o,
	// Core side.
	input wire logic trace_valid_i,
	input wire logic [2:0] trace_code_i,
	input wire logic [31:0] trace_pc_i,
	output logic trace_ready_o,
	output logic debug_exc_o,
	output logic debug_break_flag_o
);
	// ----------------------------------------------------------------
	// Pin synchronisers and trace buffer.
	// ----------------------------------------------------------------
	logic [4:0] pins_s;
	logic tck_s;
	logic tms_s;
	logic dms_s;
	logic tdi_s;
	logic dboot_s;
	logic tap_rst_n;

	// The test clock is sampled as data on the system clock.
	sdp_sync #(
		.W(5)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.d_i({tck_i, tms_i, dms_i, tdi_i, debugboot_i}),
		.q_o(pins_s)
	);

	assign tck_s = pins_s[4];
	assign tms_s = pins_s[3];
	assign dms_s = pins_s[2];
	assign tdi_s = pins_s[1];
	assign dboot_s = pins_s[0];
	// Test reset low holds the port in reset without a clock.
	assign tap_rst_n = arst_n_i & trst_n_i;

	sdp_fifo_if #(
		.W(`SDP_FIFO_W)
	) fq ();

	sdp_fifo #(
		.W(`SDP_FIFO_W),
		.DEPTH(`SDP_FIFO_DEPTH),
		.AW(`SDP_FIFO_AW)
	) u_fifo (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.f(fq.store)
	);

	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	sdp_pkg::sdp_state_t s_q;
	sdp_pkg::sdp_state_t s_d;
	logic rise;
	logic fall;
	logic beat;
	logic load_pc;
	logic [2:0] pop_code;

	assign fq.wdata = {trace_code_i, trace_pc_i};
	assign fq.wvalid = trace_valid_i && s_q.real_mode;
	assign rise = tck_s && !s_q.tck_p;
	assign fall = !tck_s && s_q.tck_p;
	assign beat = s_q.real_mode && (s_q.div_cnt == `SDP_TRACE_DIV - 4'h1);
	assign load_pc = beat && !s_q.dclk && (s_q.pc_cnt == '0);
	assign fq.rready = load_pc;
	assign pop_code = fq.rdata[`SDP_FIFO_W-1 -: 3];

	// ----------------------------------------------------------------
	// Next state.
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.tck_p = tck_s;
		// Debug-boot follows the pin each cycle, with no hold.
		s_d.exc = dboot_s;

		if (rise) begin
			// Mode selects sampled on the rising test clock.
			s_d.dms = dms_s;
			case (s_q.tap)
				sdp_pkg::tap_reset: begin
					s_d.tap = tms_s ? sdp_pkg::tap_reset : sdp_pkg::tap_idle;
				end
				sdp_pkg::tap_idle: begin
					s_d.tap = tms_s ? sdp_pkg::tap_sel_dr : sdp_pkg::tap_idle;
				end
				sdp_pkg::tap_sel_dr: begin
					s_d.tap = tms_s ? sdp_pkg::tap_sel_ir : sdp_pkg::tap_cap_dr;
				end
				sdp_pkg::tap_cap_dr: begin
					s_d.tap = tms_s ? sdp_pkg::tap_ex1_dr : sdp_pkg::tap_sh_dr;
				end
				sdp_pkg::tap_sh_dr: begin
					s_d.tap = tms_s ? sdp_pkg::tap_ex1_dr : sdp_pkg::tap_sh_dr;
				end
				sdp_pkg::tap_ex1_dr: begin
					s_d.tap = tms_s ? sdp_pkg::tap_up_dr : sdp_pkg::tap_pa_dr;
				end
				sdp_pkg::tap_pa_dr: begin
					s_d.tap = tms_s ? sdp_pkg::tap_ex2_dr : sdp_pkg::tap_pa_dr;
				end
				sdp_pkg::tap_ex2_dr: begin
					s_d.tap = tms_s ? sdp_pkg::tap_up_dr : sdp_pkg::tap_sh_dr;
				end
				sdp_pkg::tap_up_dr: begin
					s_d.tap = tms_s ? sdp_pkg::tap_sel_dr : sdp_pkg::tap_idle;
				end
				sdp_pkg::tap_sel_ir: begin
					s_d.tap = tms_s ? sdp_pkg::tap_reset : sdp_pkg::tap_cap_ir;
				end
				sdp_pkg::tap_cap_ir: begin
					s_d.tap = tms_s ? sdp_pkg::tap_ex1_ir : sdp_pkg::tap_sh_ir;
				end
				sdp_pkg::tap_sh_ir: begin
					s_d.tap = tms_s ? sdp_pkg::tap_ex1_ir : sdp_pkg::tap_sh_ir;
				end
				sdp_pkg::tap_ex1_ir: begin
					s_d.tap = tms_s ? sdp_pkg::tap_up_ir : sdp_pkg::tap_pa_ir;
				end
				sdp_pkg::tap_pa_ir: begin
					s_d.tap = tms_s ? sdp_pkg::tap_ex2_ir : sdp_pkg::tap_pa_ir;
				end
				sdp_pkg::tap_ex2_ir: begin
					s_d.tap = tms_s ? sdp_pkg::tap_up_ir : sdp_pkg::tap_sh_ir;
				end
				sdp_pkg::tap_up_ir: begin
					s_d.tap = tms_s ? sdp_pkg::tap_sel_dr : sdp_pkg::tap_idle;
				end
				default: begin
					s_d.tap = sdp_pkg::tap_reset;
				end
			endcase

			// Register actions of the state being left.
			case (s_q.tap)
				sdp_pkg::tap_reset: begin
					s_d.ir = `SDP_IR_RESET;
				end
				sdp_pkg::tap_cap_ir: begin
					s_d.ir_sh = `SDP_IR_CAPTURE;
				end
				sdp_pkg::tap_sh_ir: begin
					s_d.ir_sh = {tdi_s, s_q.ir_sh[`SDP_IR_W-1:1]};
				end
				sdp_pkg::tap_up_ir: begin
					s_d.ir = s_q.ir_sh;
				end
				sdp_pkg::tap_cap_dr: begin
					s_d.dr_sh = (s_q.ir == `SDP_INS_CTRL) ? s_q.ctrl : '0;
				end
				sdp_pkg::tap_sh_dr: begin
					if (s_q.ir == `SDP_INS_CTRL) begin
						s_d.dr_sh = {tdi_s, s_q.dr_sh[`SDP_CTRL_W-1:1]};
					end else begin
						s_d.dr_sh[0] = tdi_s;
					end
				end
				sdp_pkg::tap_up_dr: begin
					if (s_q.ir == `SDP_INS_CTRL) begin
						s_d.ctrl = s_q.dr_sh;
					end
				end
				default: begin
				end
			endcase

			// Trace mode starts when the trace instruction is updated with debug select low.
			if (s_q.tap == sdp_pkg::tap_up_ir && s_q.ir_sh == `SDP_INS_TRACE && !dms_s) begin
				s_d.real_mode = 1'b1;
				s_d.div_cnt = '0;
				s_d.dclk = 1'b0;
				s_d.pc_cnt = '0;
			end
		end

		// Outside trace mode, test output changes only on the falling test clock.
		if (fall && !s_q.real_mode) begin
			s_d.tdo_oe = (s_q.tap == sdp_pkg::tap_sh_ir) || (s_q.tap == sdp_pkg::tap_sh_dr);
			s_d.tdo = (s_q.tap == sdp_pkg::tap_sh_ir) ? s_q.ir_sh[0] : s_q.dr_sh[0];
		end

		// Trace output paced by a divided enable.
		if (s_q.real_mode) begin
			s_d.tdo_oe = 1'b1;
			s_d.pcst_oe = 1'b1;
			s_d.div_cnt = beat ? '0 : s_q.div_cnt + 4'h1;
			if (beat) begin
				s_d.dclk = !s_q.dclk;
				if (!s_q.dclk) begin
					if (s_q.pc_cnt != '0) begin
						s_d.tdo = s_q.pc_sh[0];
						s_d.pc_sh = {1'b0, s_q.pc_sh[`SDP_PC_W-1:1]};
						s_d.pc_cnt = s_q.pc_cnt - 6'h1;
						s_d.pcst = `SDP_CODE_SEQUENTIAL;
					end else if (fq.rvalid) begin
						// Status code of the traced event.
						s_d.pcst = pop_code;
						if (pop_code == `SDP_CODE_JUMP_PC || pop_code == `SDP_CODE_EXCEPTION) begin
							s_d.pc_sh = fq.rdata[`SDP_PC_W-1:0];
							s_d.pc_cnt = `SDP_PC_BITS;
						end
					end else begin
						s_d.pcst = `SDP_CODE_STALL;
					end
				end
			end
		end

		// Low test input acts as the debug interrupt in trace mode.
		if (s_q.real_mode && !tdi_s) begin
			s_d.real_mode = 1'b0;
			s_d.ir = `SDP_INS_BYPASS;
			s_d.tdo_oe = 1'b0;
			s_d.pcst_oe = 1'b0;
			s_d.dclk = 1'b0;
			s_d.pc_cnt = '0;
			s_d.pcst = `SDP_CODE_DEBUG;
		end

		// Debug-boot sets the break flag, winning over a clear.
		if (dboot_s) begin
			s_d.ctrl[`SDP_CTRL_BRK_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			s_q <= '0;
			s_q.tap <= sdp_pkg::tap_reset;
			s_q.ir <= `SDP_IR_RESET;
			s_q.ctrl <= `SDP_CTRL_RESET;
			s_q.pcst <= `SDP_CODE_DEBUG;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs.
	// ----------------------------------------------------------------
	assign tdo_o = s_q.tdo;
	assign tdo_oe_o = s_q.tdo_oe;
	assign dclk_o = s_q.dclk;
	assign pcst_o = s_q.pcst;
	assign pcst_oe_o = s_q.pcst_oe;
	assign trace_ready_o = fq.wready;
	assign debug_exc_o = s_q.exc;
	assign debug_break_flag_o = s_q.ctrl[`SDP_CTRL_BRK_BIT];

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	a_shift_ir_in: assert property (
		@(posedge clk_sys_i) disable iff (!tap_rst_n)
		rise && s_q.tap == sdp_pkg::tap_sh_ir |=> s_q.ir_sh[`SDP_IR_W-1] == $past(tdi_s))
		else $error("Instruction shift did not take the test input.");

	a_tdo_on_fall: assert property (
		@(posedge clk_sys_i) disable iff (!tap_rst_n)
		$changed(s_q.tdo) && !$past(s_q.real_mode) && !s_q.real_mode |-> $past(fall))
		else $error("Test output changed away from a falling test clock.");

	a_tdo_released: assert property (
		@(posedge clk_sys_i) disable iff (!tap_rst_n)
		fall && !s_q.real_mode && s_q.tap == sdp_pkg::tap_idle |=> !tdo_oe_o)
		else $error("Test output driven while nothing shifts.");

	a_tms_steers: assert property (
		@(posedge clk_sys_i) disable iff (!tap_rst_n)
		rise && tms_s && s_q.tap == sdp_pkg::tap_idle |=> s_q.tap == sdp_pkg::tap_sel_dr)
		else $error("Mode select did not steer the controller.");

	a_dms_sampled: assert property (
		@(posedge clk_sys_i) disable iff (!tap_rst_n)
		rise |=> s_q.dms == $past(dms_s))
		else $error("Debug select not sampled on the test clock rise.");

	a_pcst_debug: assert property (
		@(posedge clk_sys_i) disable iff (!tap_rst_n)
		s_q.real_mode && !tdi_s |=> pcst_o == `SDP_CODE_DEBUG && !pcst_oe_o)
		else $error("Status code not debug after leaving trace.");

	a_boot_level: assert property (
		@(posedge clk_sys_i) disable iff (!tap_rst_n)
		##1 debug_exc_o == $past(dboot_s))
		else $error("Debug exception does not follow the boot level.");

	a_break_set: assert property (
		@(posedge clk_sys_i) disable iff (!tap_rst_n)
		dboot_s |=> debug_break_flag_o)
		else $error("Break flag not set by debug-boot.");

	a_dclk_paced: assert property (
		@(posedge clk_sys_i) disable iff (!tap_rst_n)
		beat && tdi_s |=> dclk_o != $past(dclk_o))
		else $error("Debug clock did not toggle on a trace beat.");

	a_pc_serial: assert property (
		@(posedge clk_sys_i) disable iff (!tap_rst_n)
		beat && tdi_s && !s_q.dclk && s_q.pc_cnt != '0 |=> tdo_o == $past(s_q.pc_sh[0]))
		else $error("Trace program counter bit not on the test output.");

	a_dint_stops: assert property (
		@(posedge clk_sys_i) disable iff (!tap_rst_n)
		s_q.real_mode && !tdi_s |=> !s_q.real_mode ##1 !dclk_o)
		else $error("Debug interrupt did not end trace mode.");

	a_tap_hold_reset: assert property (
		@(posedge clk_sys_i) disable iff (!tap_rst_n)
		rise && tms_s && s_q.tap == sdp_pkg::tap_reset |=> s_q.tap == sdp_pkg::tap_reset)
		else $error("Controller left reset with mode select high.");
endmodule

`default_nettype wire

// [tb/sdp_probe_model.sv]
`timescale 1ns/1ns
`default_nettype none

module sdp_probe_model (
	// Clock.
	input wire logic clk_sys_i,
	// Probe pins.
	output logic tck_o,
	output logic tms_o,
	output logic dms_o,
	output logic tdi_o,
	output logic trst_n_o,
	output logic debugboot_o,
	input wire logic tdo_i,
	input wire logic tdo_oe_i
);
	// ----------------------------------------------------------------
	// Idle probe: test reset low, selects pulled high, clock still.
	// ----------------------------------------------------------------
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		dms_o = 1'b1;
		tdi_o = 1'b1;
		trst_n_o = 1'b0;
		debugboot_o = 1'b0;
	end

	// Static pins; a low test input in trace mode interrupts the trace.
	task pins(input logic rst_n, input logic dm, input logic db, input logic di);
		@(posedge clk_sys_i);
		trst_n_o <= rst_n;
		dms_o <= dm;
		debugboot_o <= db;
		tdi_o <= di;
		@(posedge clk_sys_i);
	endtask

	// One test clock period, even duty, output sampled before the rise.
	task tck_cycle(input logic t_ms, input logic t_di, output logic t_do, output logic t_oe);
		tms_o <= t_ms;
		tdi_o <= t_di;
		repeat (5) @(posedge clk_sys_i);
		// A released output reads as the inverse of its last value.
		t_do = tdo_oe_i ? tdo_i : !tdo_i;
		t_oe = tdo_oe_i;
		tck_o <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		tck_o <= 1'b0;
	endtask

	// Scan from idle through one register and back to idle.
	task scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout,
		output logic oe_s, output logic oe_a);
		logic d;
		logic o;
		int i;
		oe_s = 1'b1;
		dout = 32'h0000_0000;
		tck_cycle(1'b1, 1'b1, d, o);
		if (ir) begin
			tck_cycle(1'b1, 1'b1, d, o);
		end
		tck_cycle(1'b0, 1'b1, d, o);
		tck_cycle(1'b0, 1'b1, d, o);
		for (i = 0; i < n; i++) begin
			tck_cycle(i == n - 1, din[i], d, o);
			dout[i] = d;
			oe_s = oe_s & o;
		end
		tck_cycle(1'b1, 1'b1, d, o);
		oe_a = o;
		tck_cycle(1'b0, 1'b1, d, o);
		tms_o <= 1'b1;
		tdi_o <= 1'b1;
		@(posedge clk_sys_i);
	endtask
endmodule

`default_nettype wire

// [tb/tb_scan_and_trace_debug_port.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_scan_and_trace_debug_port;
	logic clk_sys_i, arst_n_i, trace_valid, tck, tms, dms, tdi, trst_n, dboot;
	logic tdo, tdo_oe, dclk, pcst_oe, t_ready, d_exc, brk, oe_s, oe_a, push_done, full, dlast;
	logic [2:0] trace_code, pcst;
	logic [31:0] trace_pc, dout;
	logic [4:0] q[$];
	int bad_count, compares;

	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	sdp_probe_model probe_u (.clk_sys_i(clk_sys_i), .tck_o(tck), .tms_o(tms), .dms_o(dms),
		.tdi_o(tdi), .trst_n_o(trst_n), .debugboot_o(dboot), .tdo_i(tdo), .tdo_oe_i(tdo_oe));

	sdp_debug_port dut_u (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .tck_i(tck), .tms_i(tms),
		.dms_i(dms), .tdi_i(tdi), .trst_n_i(trst_n), .debugboot_i(dboot), .tdo_o(tdo),
		.tdo_oe_o(tdo_oe), .dclk_o(dclk), .pcst_o(pcst), .pcst_oe_o(pcst_oe),
		.trace_valid_i(trace_valid), .trace_code_i(trace_code), .trace_pc_i(trace_pc),
		.trace_ready_o(t_ready), .debug_exc_o(d_exc), .debug_break_flag_o(brk));

	// ----------------------------------------------------------------
	// Comparison and verdict.
	// ----------------------------------------------------------------
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task results();
		$display("bad_count=%0d compares=%0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clk_sys_i);
		bad_count++;
		results();
	end

	// ----------------------------------------------------------------
	// Scan scenarios.
	// ----------------------------------------------------------------
	task t_reset();
		check("tdo_oe", tdo_oe, 1'b0);
		check("pcst", pcst, 3'h0);
		check("pcst_oe", pcst_oe, 1'b0);
		check("dclk", dclk, 1'b0);
		check("exc", d_exc, 1'b0);
		check("brk", brk, 1'b0);
		check("ready", t_ready, 1'b1);
	endtask

	task t_scan();
		probe_u.tck_cycle(1'b0, 1'b1, oe_s, oe_a);
		probe_u.scan(1'b1, 4, 32'h0000_0009, dout, oe_s, oe_a);
		check("ir capture", dout, 32'h0000_0001);
		check("oe shift", oe_s, 1'b1);
		check("oe after", oe_a, 1'b0);
		probe_u.scan(1'b0, 32, 32'hA5A5_0F0F, dout, oe_s, oe_a);
		check("ctrl reset", dout, 32'h0000_0000);
		probe_u.pins(1'b1, 1'b1, 1'b1, 1'b1);
		repeat (6) @(posedge clk_sys_i);
		check("exc on", d_exc, 1'b1);
		check("brk on", brk, 1'b1);
		probe_u.pins(1'b1, 1'b1, 1'b0, 1'b1);
		repeat (6) @(posedge clk_sys_i);
		check("exc off", d_exc, 1'b0);
		probe_u.scan(1'b0, 32, 32'h0000_0000, dout, oe_s, oe_a);
		check("ctrl read", dout, 32'hA5A5_1F0F);
		probe_u.scan(1'b1, 4, 32'h0000_000F, dout, oe_s, oe_a);
		probe_u.scan(1'b0, 4, 32'h0000_000B, dout, oe_s, oe_a);
		check("bypass", dout, 32'h0000_0006);
		probe_u.scan(1'b1, 4, 32'h0000_0008, dout, oe_s, oe_a);
		repeat (6) @(posedge clk_sys_i);
		check("no trace", pcst_oe, 1'b0);
		probe_u.scan(1'b1, 4, 32'h0000_0009, dout, oe_s, oe_a);
		probe_u.pins(1'b0, 1'b1, 1'b0, 1'b1);
		probe_u.pins(1'b1, 1'b1, 1'b0, 1'b1);
		probe_u.tck_cycle(1'b1, 1'b1, oe_s, oe_a);
		probe_u.tck_cycle(1'b0, 1'b1, oe_s, oe_a);
		probe_u.scan(1'b0, 32, 32'hFFFF_FFFF, dout, oe_s, oe_a);
		check("trst bypass", dout, 32'hFFFF_FFFE);
	endtask

	// ----------------------------------------------------------------
	// Trace scenario.
	// ----------------------------------------------------------------
	task enq(input logic [2:0] c, input logic [31:0] p);
		int b;
		q.push_back({c, 2'b00});
		if (c == 3'h6 || c == 3'h4) begin
			for (b = 0; b < 32; b++) q.push_back({3'h3, 1'b1, p[b]});
		end
	endtask

	task push();
		logic [2:0] codes [8];
		int j, k;
		codes = '{3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h7};
		for (j = 0; j < 28; j++) begin
			trace_valid <= 1'b1;
			trace_code <= (j < 8) ? codes[j] : 3'h3;
			trace_pc <= 32'hC0DE_0000 + j;
			k = 0;
			do begin
				@(posedge clk_sys_i);
				k++;
				if (t_ready !== 1'b1) full = 1'b1;
			end while (t_ready !== 1'b1 && k < 300);
			check("ready wait", t_ready, 1'b1);
			enq(trace_code, trace_pc);
		end
		trace_valid <= 1'b0;
		push_done = 1'b1;
		check("fifo full", full, 1'b1);
	endtask

	task rise();
		int k;
		k = 0;
		do begin
			dlast = dclk;
			@(posedge clk_sys_i);
			#1;
			k++;
		end while (!(dclk === 1'b1 && dlast === 1'b0) && k < 20);
		if (k == 20) check("dclk", 32'h0000_0000, 32'h0000_0001);
	endtask

	task mon();
		logic started;
		logic [4:0] e;
		started = 1'b0;
		while (!push_done || q.size() > 0) begin
			rise();
			if (pcst !== 3'h7) started = 1'b1;
			if (started && q.size() > 0) begin
				e = q.pop_front();
				check("pcst", pcst, e[4:2]);
				if (e[1]) check("tdo pc", tdo, e[0]);
			end
		end
		rise();
		check("pcst empty", pcst, 3'h7);
	endtask

	task t_trace();
		probe_u.pins(1'b1, 1'b0, 1'b0, 1'b1);
		probe_u.scan(1'b1, 4, 32'h0000_0008, dout, oe_s, oe_a);
		probe_u.pins(1'b1, 1'b1, 1'b0, 1'b1);
		repeat (6) @(posedge clk_sys_i);
		check("trace on", pcst_oe, 1'b1);
		fork
			push();
			mon();
		join
		@(posedge clk_sys_i);
		probe_u.pins(1'b1, 1'b1, 1'b0, 1'b0);
		repeat (6) @(posedge clk_sys_i);
		check("trace off", pcst_oe, 1'b0);
		check("pcst off", pcst, 3'h0);
		check("tdo off", tdo_oe, 1'b0);
		probe_u.pins(1'b1, 1'b1, 1'b0, 1'b1);
	endtask

	initial begin
		bad_count = 0;
		compares = 0;
		arst_n_i = 1'b0;
		trace_valid = 1'b0;
		trace_code = 3'h0;
		trace_pc = 32'h0000_0000;
		push_done = 1'b0;
		full = 1'b0;
		dlast = 1'b0;
		repeat (12) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		probe_u.pins(1'b1, 1'b1, 1'b0, 1'b1);
		repeat (4) @(posedge clk_sys_i);
		t_reset();
		t_scan();
		t_trace();
		results();
	end
endmodule

`default_nettype wire
